/* File: dv/tpw_pin_load.sv */
/* port pin with an external load and a pull resistor.
   assumes the timer drives data and an active-low enable */
`timescale 1ns/1ps
module tpw_pin_load #(
  parameter PULL = 1'b1
) (
  // from the timer
  input wire PIN_O,
  input wire PIN_OE_N,
  // pin level seen back
  output wire PIN_I
);
  // released pin sits at the pull level, never at the old data
  assign PIN_I = PIN_OE_N ? PULL : PIN_O;
endmodule // tpw_pin_load

/* File: dv/tpw_timer_properties.sv */
/* checker for tpw_timer: register port, pin override and flag timing.
   assumes binding to tpw_timer, one clock domain, default map offsets */
`timescale 1ns/1ps
`include "tpw_defines.vh"
module tpw_timer_chk #(
  parameter AW = 4
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // register port
  input wire [AW-1:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  // pins
  input wire PIN_A_O,
  input wire PIN_A_OE_N,
  input wire PIN_B_O,
  input wire PIN_B_OE_N,
  // flags
  input wire OVERFLOW_FLAG,
  input wire COMPARE_FLAG_A,
  input wire COMPARE_FLAG_B
);
  reg [10:0] ctrl_reg; // mirror of control word
  reg [3:0] dir_reg; // mirror of direction and port bits
  reg [2:0] clr_reg; // flag clear bits written last cycle
  // pwm mode with undivided tick: flags due within one period
  wire pwm_run = ctrl_reg[5:3] == 3'h1 && ctrl_reg[0];
  // mirrors follow writes on the same edge as the registers
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= 11'h000;
      dir_reg <= 4'h0;
      clr_reg <= 3'h0;
    end else begin
      clr_reg <= (WR && ADDR == `TPW_OFF_FLAGS) ? WDATA[2:0] : 3'h0;
      if (WR && ADDR == `TPW_OFF_CTRL) ctrl_reg <= WDATA[10:0];
      if (WR && ADDR == `TPW_OFF_DIR) dir_reg <= WDATA[3:0];
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_oe_a; PIN_A_OE_N == !dir_reg[0]; endproperty
  property p_oe_b; PIN_B_OE_N == !dir_reg[1]; endproperty
  property p_rd_idle; !RD |=> RDATA == 16'h0000; endproperty
  property p_port_a; ctrl_reg[9:8] == `TPW_COM_OFF |-> PIN_A_O == dir_reg[2]; endproperty
  property p_port_b; ctrl_reg[7:6] == `TPW_COM_OFF |-> PIN_B_O == dir_reg[3]; endproperty
  property p_ovf_clr; $fell(OVERFLOW_FLAG) |-> clr_reg[0]; endproperty
  property p_cmpa_clr; $fell(COMPARE_FLAG_A) |-> clr_reg[1]; endproperty
  property p_ovf_due; pwm_run && clr_reg[0] |-> ##[0:1000] OVERFLOW_FLAG; endproperty
  property p_cmpa_due; pwm_run && clr_reg[1] |-> ##[0:1000] COMPARE_FLAG_A; endproperty
  a_oe_a: assert property (p_oe_a) else $error("pin a enable off");
  a_oe_b: assert property (p_oe_b) else $error("pin b enable off");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_port_a: assert property (p_port_a) else $error("pin a not port data");
  a_port_b: assert property (p_port_b) else $error("pin b not port data");
  a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag lost");
  a_cmpa_clr: assert property (p_cmpa_clr) else $error("compare flag lost");
  a_ovf_due: assert property (p_ovf_due) else $error("no overflow");
  a_cmpa_due: assert property (p_cmpa_due) else $error("no compare match");
  c_phase_a: cover property (pwm_run && ctrl_reg[2:0] == `TPW_WGM_PC_A);
  c_toggle: cover property (ctrl_reg[7:6] == `TPW_COM_TOG && $changed(PIN_B_O));
  c_ovf: cover property ($rose(OVERFLOW_FLAG));
endmodule // tpw_timer_chk

bind tpw_timer tpw_timer_chk #(.AW(AW)) chk_u (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_A_O(PIN_A_O),
  .PIN_A_OE_N(PIN_A_OE_N), .PIN_B_O(PIN_B_O), .PIN_B_OE_N(PIN_B_OE_N),
  .OVERFLOW_FLAG(OVERFLOW_FLAG), .COMPARE_FLAG_A(COMPARE_FLAG_A),
  .COMPARE_FLAG_B(COMPARE_FLAG_B));

/* File: dv/tpw_timer_tb_top.sv */
/* bench for tpw_timer: duty per waveform mode, pin override, flags.
   assumes the pin load model and the bound checker */
`timescale 1ns/1ps
`include "tpw_defines.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("FAIL %s exp %0d got %0d", nm, e, g); end end
module tpw_timer_tb_top;
  logic clk = 1'b0; // core clock, 50 MHz
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic osc = 1'b0; // free oscillator, async path left idle
  wire [15:0] rdata;
  wire pa_i, pa_o, pa_oe_n, pb_i, pb_o, pb_oe_n;
  wire ovf, cfa, cfb; // flag outputs
  int n_checks = 0;
  int n_mismatch = 0;
  int seed = 32'hc5ef199a;
  logic [15:0] d;
  // rows: mode, out mode a, out mode b, cmp a, cmp b, clock sel
  int tbl[7][6] = '{'{3,2,2,100,0,1}, '{3,3,1,255,7,1}, '{7,2,3,99,30,1},
    '{1,2,3,0,200,1}, '{1,3,2,255,64,1}, '{5,2,2,80,20,1}, '{3,2,3,40,200,2}};
  always #10 clk = ~clk;
  always #37 osc = ~osc;
  tpw_timer dut_u (.CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .OSC_IN(osc), .PIN_A_I(pa_i), .PIN_A_O(pa_o), .PIN_A_OE_N(pa_oe_n),
    .PIN_B_I(pb_i), .PIN_B_O(pb_o), .PIN_B_OE_N(pb_oe_n), .OVERFLOW_FLAG(ovf),
    .COMPARE_FLAG_A(cfa), .COMPARE_FLAG_B(cfb));
  // pin a pulled up, pin b pulled down
  tpw_pin_load #(.PULL(1'b1)) load_a (.PIN_O(pa_o), .PIN_OE_N(pa_oe_n), .PIN_I(pa_i));
  tpw_pin_load #(.PULL(1'b0)) load_b (.PIN_O(pb_o), .PIN_OE_N(pb_oe_n), .PIN_I(pb_i));
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  // high ticks of the waveform over two periods, from a walked count sequence
  function automatic int exp_high(int fast, int com, int c, int top);
    int q[$];
    int st;
    int h;
    st = 0;
    h = 0;
    for (int i = 0; i <= top; i++) q.push_back(i);
    if (!fast) for (int i = top - 1; i > 0; i--) q.push_back(i);
    // first pass only settles the state
    for (int p = 0; p < 3; p++) foreach (q[i]) begin
      if (fast && q[i] == 0 && com >= 2) st = (com == 2);
      if (p > 0) h += st;
      if (fast && q[i] == c) st = (com == 1) ? !st : (com == 3);
      if (!fast && q[i] == c) st = (i < top) ? (com == 3) : (com == 2);
    end
    return h;
  endfunction
  task automatic run(input int m, ca, cb, va, vb, s);
    int top, dv, per, ha, hb;
    top = m[2] ? va : 255;
    dv = (s == 2) ? 8 : 1;
    per = (m[1] ? top + 1 : 2 * top) * dv;
    // stopped timer at zero so every row starts clean
    wr_reg(`TPW_OFF_CTRL, 16'h0000);
    wr_reg(`TPW_OFF_CNT, 16'h0000);
    wr_reg(`TPW_OFF_CMPA, 16'(va));
    wr_reg(`TPW_OFF_CMPB, 16'(vb));
    wr_reg(`TPW_OFF_CTRL, 16'(ca * 256 + cb * 64 + s * 8 + m));
    repeat (2 * per + 4) @(posedge clk);
    wr_reg(`TPW_OFF_FLAGS, 16'h0007);
    ha = 0;
    hb = 0;
    repeat (2 * per) begin
      @(negedge clk);
      ha += pa_i;
      hb += pb_i;
    end
    @(posedge clk);
    `CHK("duty a", exp_high(m[1], ca, va, top) * dv, ha)
    `CHK("duty b", exp_high(m[1], cb, vb, top) * dv, hb)
    rd_reg(`TPW_OFF_FLAGS, d);
    `CHK("flags", 3'b111, d[2:0])
    `CHK("flag outputs", 3'b111, {cfb, cfa, ovf})
    rd_reg(`TPW_OFF_CNT, d);
    `CHK("count range", 1'b1, d[7:0] <= 8'(top))
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    wrap_up;
  end
  initial begin
    int m, va;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // pin read-back passes a synchroniser: let it settle
    repeat (5) @(posedge clk);
    rd_reg(`TPW_OFF_DIR, d);
    `CHK("released pins", 2'b01, d[5:4])
    wr_reg(`TPW_OFF_DIR, 16'h000b);
    repeat (4) @(posedge clk);
    rd_reg(`TPW_OFF_DIR, d);
    `CHK("port data pins", 2'b10, d[5:4])
    for (int i = 0; i < 7; i++) run(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], 1 + (i == 6));
    // random rows in the four pwm modes
    repeat (4) begin
      m = 1 + 2 * ($unsigned($random(seed)) % 4);
      va = 2 + $unsigned($random(seed)) % 254;
      run(m, 2 + $unsigned($random(seed)) % 2, 2 + $unsigned($random(seed)) % 2, va,
        $unsigned($random(seed)) % (va + 1), 1);
    end
    wrap_up;
  end
endmodule // tpw_timer_tb_top

/* File: logic/tpw_defines.vh */
/*
 * Shared constants of the 8-bit PWM timer: register offsets, field
 * positions, reset values, waveform mode codes and prescale taps.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef TPW_DEFINES_VH
`define TPW_DEFINES_VH

// register offsets on the plain register port
`define TPW_OFF_CTRL 4'h0
`define TPW_OFF_CMPA 4'h1
`define TPW_OFF_CMPB 4'h2
`define TPW_OFF_CNT 4'h3
`define TPW_OFF_FLAGS 4'h4
`define TPW_OFF_DIR 4'h5

// control register field positions
`define TPW_CTRL_WGM_LSB 0
`define TPW_CTRL_CS_LSB 3
`define TPW_CTRL_COMB_LSB 6
`define TPW_CTRL_COMA_LSB 8
`define TPW_CTRL_ASYNC_BIT 10
`define TPW_CTRL_RST 11'h000

// flag register bit positions
`define TPW_FLAG_OVF 0
`define TPW_FLAG_CMPA 1
`define TPW_FLAG_CMPB 2

// waveform mode codes
`define TPW_WGM_FAST_FF 3'h3
`define TPW_WGM_FAST_A 3'h7
`define TPW_WGM_PC_FF 3'h1
`define TPW_WGM_PC_A 3'h5

// compare output mode codes
`define TPW_COM_OFF 2'h0
`define TPW_COM_TOG 2'h1
`define TPW_COM_NINV 2'h2
`define TPW_COM_INV 2'h3

// counter extremes
`define TPW_BOTTOM 8'h00
`define TPW_MAX 8'hff

// prescale divide counts, minus one
`define TPW_DIV8 10'h007
`define TPW_DIV32 10'h01f
`define TPW_DIV64 10'h03f
`define TPW_DIV128 10'h07f
`define TPW_DIV256 10'h0ff
`define TPW_DIV1024 10'h3ff

`endif

/* File: logic/tpw_prescale.v */
/*
 * Timer tick generator: divides the core clock, or counts edges of the
 * external oscillator, and emits a one-cycle tick.
 * Assumes the oscillator input is already synchronised by the caller.
 */
`timescale 1ns/1ps
`include "tpw_defines.vh"

module tpw_prescale #(
  parameter DIV_W = 10
) (
  // clock and reset
  input wire CLK,
  input wire RST,
  // control
  input wire [2:0] SEL,
  input wire ASYNC_SEL,
  input wire OSC_EDGE,
  // tick out
  output wire TICK
);

  reg [DIV_W-1:0] div_reg; // free running divider
  reg [DIV_W-1:0] limit; // terminal count for selected tap
  reg base_tick; // source clock event

  // source event: core edge or oscillator edge
  always @* begin
    base_tick = ASYNC_SEL ? OSC_EDGE : 1'b1;
  end

  // tap decode; 0 stops the timer
  always @* begin
    case (SEL)
      3'h2: limit = `TPW_DIV8;
      3'h3: limit = `TPW_DIV32;
      3'h4: limit = `TPW_DIV64;
      3'h5: limit = `TPW_DIV128;
      3'h6: limit = `TPW_DIV256;
      3'h7: limit = `TPW_DIV1024;
      default: limit = {DIV_W{1'b0}};
    endcase
  end

  // divider, restarts at every terminal count
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_reg <= {DIV_W{1'b0}};
    end else if (SEL == 3'h0) begin
      div_reg <= {DIV_W{1'b0}};
    end else if (base_tick) begin
      if (div_reg >= limit) div_reg <= {DIV_W{1'b0}};
      else div_reg <= div_reg + 1'b1;
    end
  end

  assign TICK = (SEL != 3'h0) && base_tick && (div_reg >= limit); // [R19] [R20]

endmodule // tpw_prescale

/* File: logic/tpw_timer.v */
/*
 * 8-bit timer with two compare channels in fast and phase-correct PWM.
 * Holds register file, counter, compare buffers, waveform state and
 * pin override. Assumes a plain register port driven on CORE_CLK, and
 * port pins whose pad logic resolves drive from the enable outputs.
 */
`timescale 1ns/1ps
`include "tpw_defines.vh"

// Summary of operation
// R1: modes 3 and 7 count up only
// R2: fast top is 0xff or compare A
// R3: fast: clear on match, set at bottom
// R4: clear counter tick after top, bottom action
// R5: fast overflow flag set at top
// R6: mode two normal, three inverted
// R7: pin shows waveform only when direction output
// R8: compare A extremes: spike or constant
// R9: mode one toggles on match
// R10: compare writes buffered until update point
// R11: modes 1 and 5 count up down
// R12: phase top is 0xff or compare A
// R13: phase: clear up-match, set down-match
// R14: top held one tick then down
// R15: phase overflow flag set at bottom
// R16: compare A extremes give constant levels
// R17: leaving MAX fixes output at top
// R18: missed up-match repaired at bottom
// R19: prescale 1 to 1024 divides core clock
// R20: tick enables core clock or oscillator
// R21: mode zero holds state, frees pin
// R22: counter write blocks next tick matches
// R23: compare flags set on active match
module tpw_timer #(
  parameter AW = 4
) (
  // clock and reset
  input wire CORE_CLK,
  input wire RST,
  // register port
  input wire [AW-1:0] ADDR,
  input wire [15:0] WDATA,
  input wire WR,
  input wire RD,
  output wire [15:0] RDATA,
  // external timer oscillator
  input wire OSC_IN,
  // port pins, channel a and b
  input wire PIN_A_I,
  output wire PIN_A_O,
  output wire PIN_A_OE_N,
  input wire PIN_B_I,
  output wire PIN_B_O,
  output wire PIN_B_OE_N,
  // raw state for the system
  output wire OVERFLOW_FLAG,
  output wire COMPARE_FLAG_A,
  output wire COMPARE_FLAG_B
);

  // control and data registers
  reg [10:0] ctrl_reg; // mode, prescale, output modes, async
  reg [7:0] buf_a_reg; // software side of compare a
  reg [7:0] buf_b_reg; // software side of compare b
  reg [7:0] act_a_reg; // active compare a
  reg [7:0] act_b_reg; // active compare b
  reg [7:0] cnt_reg; // count_value
  reg down_reg; // counting down in phase mode
  reg blk_reg; // counter written, blocks next tick
  reg [2:0] flag_reg; // overflow, compare a, compare b
  reg [3:0] dir_reg; // pin direction and port data
  reg [1:0] oc_reg; // compare_output state a, b
  reg [15:0] rdata_reg; // read data, one cycle late
  reg [2:0] osc_sync_reg; // oscillator synchroniser
  reg osc_prev_reg; // last agreed oscillator level
  // pin read-back, pads are not on the core clock
  reg [2:0] pin_a_sync_reg; // pin a stages, oldest at bit 2
  reg [2:0] pin_b_sync_reg; // pin b stages, oldest at bit 2
  reg pin_a_lvl_reg; // agreed pin a level
  reg pin_b_lvl_reg; // agreed pin b level

  // decoded fields
  wire [2:0] waveform_mode_sel = ctrl_reg[`TPW_CTRL_WGM_LSB +: 3];
  wire [2:0] clk_sel = ctrl_reg[`TPW_CTRL_CS_LSB +: 3];
  wire [1:0] com_b = ctrl_reg[`TPW_CTRL_COMB_LSB +: 2];
  wire [1:0] compare_output_mode_a = ctrl_reg[`TPW_CTRL_COMA_LSB +: 2];
  wire async_sel = ctrl_reg[`TPW_CTRL_ASYNC_BIT];

  wire fast = (waveform_mode_sel == `TPW_WGM_FAST_FF) ||
              (waveform_mode_sel == `TPW_WGM_FAST_A); // [R1]
  wire phase = (waveform_mode_sel == `TPW_WGM_PC_FF) ||
               (waveform_mode_sel == `TPW_WGM_PC_A); // [R11]
  wire top_is_a = waveform_mode_sel[2]; // modes 5 and 7
  wire [7:0] top = top_is_a ? act_a_reg : `TPW_MAX; // [R2] [R12]

  // oscillator edge: second and third stages agree on a rise
  wire osc_level = osc_sync_reg[2];
  wire osc_agree = (osc_sync_reg[1] == osc_sync_reg[2]);
  wire osc_edge = osc_agree && osc_level && !osc_prev_reg;

  wire timer_tick;

  tpw_prescale #(
    .DIV_W(10)
  ) u_pre (
    .CLK(CORE_CLK),
    .RST(RST),
    .SEL(clk_sel),
    .ASYNC_SEL(async_sel),
    .OSC_EDGE(osc_edge),
    .TICK(timer_tick)
  ); // [R20]

  // register access strobes
  wire wr_ctrl = WR && (ADDR == `TPW_OFF_CTRL);
  wire wr_a = WR && (ADDR == `TPW_OFF_CMPA);
  wire wr_b = WR && (ADDR == `TPW_OFF_CMPB);
  wire wr_cnt = WR && (ADDR == `TPW_OFF_CNT);
  wire wr_flag = WR && (ADDR == `TPW_OFF_FLAGS);
  wire wr_dir = WR && (ADDR == `TPW_OFF_DIR);

  // next-count evaluation
  wire at_top = (cnt_reg == top);
  wire at_bot = (cnt_reg == `TPW_BOTTOM);
  reg [7:0] cnt_next;
  reg down_next;
  reg wrap; // fast mode leaves top this tick
  reg upd; // compare buffers load this tick

  // match: counter equals active compare, unless blocked by a write
  wire match_a = (cnt_reg == act_a_reg) && !blk_reg; // [R22]
  wire match_b = (cnt_reg == act_b_reg) && !blk_reg; // [R22]

  // counter sequencing per mode
  always @* begin
    cnt_next = cnt_reg;
    down_next = down_reg;
    wrap = 1'b0;
    upd = 1'b0;
    if (fast) begin
      down_next = 1'b0; // [R1]
      if (at_top) begin
        cnt_next = `TPW_BOTTOM; // [R4]
        wrap = 1'b1;
        upd = 1'b1; // [R10]
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end else if (phase) begin
      if (!down_reg) begin
        if (at_top) begin
          down_next = 1'b1; // top held one tick [R14]
          cnt_next = (top == `TPW_BOTTOM) ? cnt_reg : cnt_reg - 8'h01;
          upd = 1'b1; // [R10]
        end else begin
          cnt_next = cnt_reg + 8'h01; // [R11]
        end
      end else if (at_bot) begin
        down_next = 1'b0;
        cnt_next = cnt_reg + 8'h01;
      end else begin
        cnt_next = cnt_reg - 8'h01;
      end
    end else begin
      // other modes simply count up and overrun
      cnt_next = cnt_reg + 8'h01;
      down_next = 1'b0;
    end
  end

  // waveform update for one channel
  function wf_next;
    input cur;
    input [1:0] com;
    input is_fast;
    input is_phase;
    input m;
    input wr_top;
    input dn;
    input bot;
    input [7:0] cmp;
    begin
      wf_next = cur;
      if (com == `TPW_COM_OFF) begin
        wf_next = cur; // [R21]
      end else if (is_fast) begin
        if (com == `TPW_COM_TOG) begin
          if (m) wf_next = !cur; // [R9]
        end else if (wr_top) begin
          // bottom action beats a match in the same tick, so a compare
          // at top or at max leaves a constant level [R8]
          wf_next = (com == `TPW_COM_NINV); // [R3] [R4] [R6]
        end else if (m) begin
          wf_next = (com == `TPW_COM_INV); // [R3] [R6]
        end
      end else if (is_phase && com != `TPW_COM_TOG) begin
        if (cmp == `TPW_BOTTOM) begin
          wf_next = (com == `TPW_COM_INV); // [R16]
        end else if (m && !dn) begin
          wf_next = (com == `TPW_COM_INV); // [R13] [R17]
        end else if (m && dn) begin
          wf_next = (com == `TPW_COM_NINV); // [R13] [R16]
        end else if (bot && dn) begin
          // bottom reached off the down-match level, e.g. after a start
          // above compare: restore it so the period stays symmetric [R18] [R17]
          wf_next = (com == `TPW_COM_NINV);
        end
      end
    end
  endfunction

  // a match at top turns the count, so it acts as a down-count match;
  // this is what keeps compare at max constant in phase mode
  wire dn_eff = down_reg || (phase && at_top); // [R16] [R17]
  // bottom repair only for a compare the count can reach [R18]
  wire sym_a = at_bot && (act_a_reg <= top);
  wire sym_b = at_bot && (act_b_reg <= top);

  // state on the next tick
  wire oc_a_next = wf_next(oc_reg[0], compare_output_mode_a, fast, phase, match_a,
                           wrap, dn_eff, sym_a, act_a_reg);
  wire oc_b_next = wf_next(oc_reg[1], com_b, fast, phase, match_b,
                           wrap, dn_eff, sym_b, act_b_reg);

  // overflow point per mode
  wire ovf_evt = fast ? at_top : (phase ? (at_bot && down_reg) : (cnt_reg == `TPW_MAX));

  // oscillator synchroniser, three stages
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      osc_sync_reg <= 3'h0;
      osc_prev_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[1:0], OSC_IN};
      if (osc_agree) osc_prev_reg <= osc_level;
    end
  end

  // pin read-back synchronisers; a level counts only once the second
  // and third stages agree, so a metastable sample never reaches software
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pin_a_sync_reg <= 3'h0;
      pin_b_sync_reg <= 3'h0;
      pin_a_lvl_reg <= 1'b0;
      pin_b_lvl_reg <= 1'b0;
    end else begin
      pin_a_sync_reg <= {pin_a_sync_reg[1:0], PIN_A_I};
      pin_b_sync_reg <= {pin_b_sync_reg[1:0], PIN_B_I};
      // disagreeing stages hold the old level
      if (pin_a_sync_reg[1] == pin_a_sync_reg[2]) pin_a_lvl_reg <= pin_a_sync_reg[2];
      if (pin_b_sync_reg[1] == pin_b_sync_reg[2]) pin_b_lvl_reg <= pin_b_sync_reg[2];
    end
  end

  // software registers
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= `TPW_CTRL_RST;
      buf_a_reg <= 8'h00;
      buf_b_reg <= 8'h00;
      dir_reg <= 4'h0;
    end else begin
      if (wr_ctrl) ctrl_reg <= WDATA[10:0]; // output modes act at once
      if (wr_a) buf_a_reg <= WDATA[7:0]; // [R10]
      if (wr_b) buf_b_reg <= WDATA[7:0]; // [R10]
      if (wr_dir) dir_reg <= WDATA[3:0];
    end
  end

  // counter, active compares, waveform state
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_reg <= 8'h00;
      down_reg <= 1'b0;
      act_a_reg <= 8'h00;
      act_b_reg <= 8'h00;
      blk_reg <= 1'b0;
      oc_reg <= 2'h0;
    end else begin
      // outside pwm modes compares act directly
      if (!(fast || phase)) begin
        act_a_reg <= buf_a_reg;
        act_b_reg <= buf_b_reg;
      end
      if (wr_cnt) begin
        cnt_reg <= WDATA[7:0];
        blk_reg <= 1'b1; // [R22]
      end else if (timer_tick) begin
        cnt_reg <= cnt_next;
        down_reg <= down_next;
        blk_reg <= 1'b0;
        oc_reg <= {oc_b_next, oc_a_next};
        if (upd) begin
          act_a_reg <= buf_a_reg; // [R10]
          act_b_reg <= buf_b_reg; // [R10]
        end
      end
    end
  end

  // sticky flags; hardware set wins over software clear
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      flag_reg <= 3'h0;
    end else begin
      if (wr_flag) flag_reg <= flag_reg & ~WDATA[2:0];
      if (timer_tick) begin
        if (ovf_evt) flag_reg[`TPW_FLAG_OVF] <= 1'b1; // [R5] [R15]
        if (match_a) flag_reg[`TPW_FLAG_CMPA] <= 1'b1; // [R23]
        if (match_b) flag_reg[`TPW_FLAG_CMPB] <= 1'b1; // [R23]
      end
    end
  end

  // read mux, data one cycle after strobe; unmapped reads zero
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rdata_reg <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        `TPW_OFF_CTRL: rdata_reg <= {5'h00, ctrl_reg};
        `TPW_OFF_CMPA: rdata_reg <= {8'h00, buf_a_reg};
        `TPW_OFF_CMPB: rdata_reg <= {8'h00, buf_b_reg};
        `TPW_OFF_CNT: rdata_reg <= {8'h00, cnt_reg};
        `TPW_OFF_FLAGS: rdata_reg <= {13'h0000, flag_reg};
        `TPW_OFF_DIR: rdata_reg <= {10'h000, pin_b_lvl_reg, pin_a_lvl_reg, dir_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign RDATA = rdata_reg;

  // pin override: waveform only when mode set, driver only when output
  assign PIN_A_O = (compare_output_mode_a != `TPW_COM_OFF) ? oc_reg[0] : dir_reg[2]; // [R21]
  assign PIN_A_OE_N = !dir_reg[0]; // [R7]
  assign PIN_B_O = (com_b != `TPW_COM_OFF) ? oc_reg[1] : dir_reg[3]; // [R21]
  assign PIN_B_OE_N = !dir_reg[1]; // [R7]

  assign OVERFLOW_FLAG = flag_reg[`TPW_FLAG_OVF];
  assign COMPARE_FLAG_A = flag_reg[`TPW_FLAG_CMPA];
  assign COMPARE_FLAG_B = flag_reg[`TPW_FLAG_CMPB];

endmodule // tpw_timer
